// ### core/spics_regs.svh
// Register offsets, field positions, reset values and shift-clock divisors
// for the serial port control and status block.
// Assumes the includer works on an 8-bit register-file address.
`ifndef SPICS_REGS_SVH
`define SPICS_REGS_SVH

// Register-file addresses
`define SPICS_CTRL_ADDR 8'hE9
`define SPICS_STAT_ADDR 8'hEA
`define SPICS_DATA_ADDR 8'hEB

// Control register fields
`define SPICS_CTRL_IE 7
`define SPICS_CTRL_EN 6
`define SPICS_CTRL_MSBF 5
`define SPICS_CTRL_MSTR 4
`define SPICS_CTRL_CPOL 3
`define SPICS_CTRL_CPHA 2
`define SPICS_CTRL_RATE_HI 1
`define SPICS_CTRL_RATE_LO 0

// Status register fields
`define SPICS_STAT_PEND 7
`define SPICS_STAT_WCOL 6
`define SPICS_STAT_MODF 5
`define SPICS_STAT_DBL 0

// Reset values
`define SPICS_CTRL_RESET 8'h00
`define SPICS_STAT_RESET 8'h00

// Oscillator divisors for rate codes 0..3
`define SPICS_DIV0 9'h004
`define SPICS_DIV1 9'h010
`define SPICS_DIV2 9'h040
`define SPICS_DIV3 9'h100

`endif

// ### core/spics_pkg.sv
// Types and shared helpers of the serial port control and status block.
// Assumes spics_regs.svh is on the include path.
`include "spics_regs.svh"

package spics_pkg;

  typedef enum logic {S_IDLE, S_XFER} spics_state_e;

  // Half period of the shift clock in oscillator cycles
  function automatic logic [7:0] spics_half(input logic [1:0] rate, input logic dbl);
    logic [8:0] div;
    case (rate)
      2'h0: div = `SPICS_DIV0;
      2'h1: div = `SPICS_DIV1;
      2'h2: div = `SPICS_DIV2;
      default: div = `SPICS_DIV3;
    endcase
    return dbl ? 8'(div >> 2) : 8'(div >> 1);
  endfunction : spics_half

  function automatic logic [7:0] spics_rev(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
      r[i] = d[7 - i];
    return r;
  endfunction : spics_rev

endpackage : spics_pkg

// ### core/spics_fifo.sv
// Transmit byte FIFO with valid/ready on both sides.
// Assumes one clock; fill and drain handshakes are synchronous to it.
`timescale 1ns/1ps

module spics_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic full, next_full;
  logic empty, next_empty;
  logic push, pop;

  always_comb
  begin
    push = i_in_valid && !full;
    pop = i_out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
    next_full = next_count == DEPTH_C;
    next_empty = next_count == '0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      full <= 1'b0;
      empty <= 1'b1;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      full <= next_full;
      empty <= next_empty;
    end
  end

  // Storage needs no reset; empty guards every read
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr];

endmodule : spics_fifo

// ### core/spics_top.sv
// Serial port control/status registers with the byte shift engine behind them.
// Assumes a register-file strobe port on the oscillator clock and pins from
// outside that domain; the slave shift clock must stay well below fosc/8.
// Operation
// RULE1: Control bit 7 gates the interrupt; bit 6 turns the whole port off or on; the code still fills the FIFO and flags write collisions while it is off.
// RULE2: Control bit 5 picks bit order: 0 LSB first, 1 MSB first.
// RULE3: Control bit 4 picks role: 0 slave clocked externally, 1 master drives clock.
// RULE4: Control bit 3 sets shift clock idle level: 0 low, 1 high.
// RULE5: Control bit 2 picks sampling: 0 leading edge, 1 trailing edge.
// RULE6: Master clock is fosc over 4/16/64/256; status bit 0 doubles it.
// RULE7: Status bits 7,6,5 are read-only flags reset to zero; bit 0 read/write.
// RULE8: Interrupt request is high only while pending flag and enable are set; the code registers it, so it follows them one cycle late.
`timescale 1ns/1ps
`include "spics_regs.svh"

module spics_top
  import spics_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  // Register-file access
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WE,
  input wire logic I_REG_RE,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  output logic O_TX_READY,
  // Interrupt request
  output logic O_IRQ,
  // Serial pins
  input wire logic I_SERIAL_SHIFT_CLOCK_PIN,
  output logic O_SERIAL_SHIFT_CLOCK_PIN,
  output logic O_SERIAL_SHIFT_CLOCK_PIN_OE,
  input wire logic I_SDI,
  output logic O_SDO,
  output logic O_SDO_OE,
  input wire logic I_SS_N
);

  spics_state_e state, next_state;
  logic [7:0] ctrl, next_ctrl;
  logic dbl, next_dbl;
  logic pend, next_pend;
  logic wcol, next_wcol;
  logic modf, next_modf;
  logic [7:0] tmr, next_tmr;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] rx_data, next_rx_data;
  logic sck_o, next_sck_o;
  logic sck_oe, next_sck_oe;
  logic sdo, next_sdo;
  logic sdo_oe, next_sdo_oe;
  logic irq, next_irq;
  logic [7:0] rdata, next_rdata;
  // Registered copy keeps the ready output straight from a flop
  logic tx_rdy, next_tx_rdy;

  // Pin synchronisers and edge history
  logic sck_m, sck_s, sck_prev;
  logic sdi_m, sdi_s;
  logic ss_m, ss_s, ss_prev;

  logic [7:0] half, load_val, load_sh, rx_next;
  logic start, pop, tick, edge_ev, set_pend, set_modf, set_wcol;
  logic stat_rd, data_wr, ss_low, ss_fall;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  spics_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(I_CLK_SYS),
    .i_rstn(I_RSTN),
    .i_in_valid(data_wr),
    .o_in_ready(fifo_in_ready),
    .i_in_data(I_REG_WDATA),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_out_data)
  );

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_prev <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      ss_m <= 1'b1;
      ss_s <= 1'b1;
      ss_prev <= 1'b1;
    end
    else
    begin
      sck_m <= I_SERIAL_SHIFT_CLOCK_PIN;
      sck_s <= sck_m;
      sck_prev <= sck_s;
      sdi_m <= I_SDI;
      sdi_s <= sdi_m;
      ss_m <= I_SS_N;
      ss_s <= ss_m;
      ss_prev <= ss_s;
    end
  end

  always_comb
  begin
    next_state = state;
    next_ctrl = ctrl;
    next_dbl = dbl;
    next_tmr = tmr;
    next_cnt = cnt;
    next_sh = sh;
    next_rx_sh = rx_sh;
    next_rx_data = rx_data;
    next_sck_o = sck_o;
    next_sdo = sdo;
    start = 1'b0;
    pop = 1'b0;
    tick = 1'b0;
    edge_ev = 1'b0;
    set_pend = 1'b0;
    set_modf = 1'b0;
    set_wcol = 1'b0;
    ss_low = !ss_s;
    ss_fall = ss_prev && !ss_s;
    stat_rd = I_REG_RE && I_REG_ADDR == `SPICS_STAT_ADDR;
    data_wr = I_REG_WE && I_REG_ADDR == `SPICS_DATA_ADDR;
    half = spics_half(ctrl[`SPICS_CTRL_RATE_HI:`SPICS_CTRL_RATE_LO], dbl); // [RULE6]
    load_val = fifo_out_valid ? fifo_out_data : 8'h00;
    load_sh = ctrl[`SPICS_CTRL_MSBF] ? load_val : spics_rev(load_val); // [RULE2]
    rx_next = rx_sh;
    if (I_REG_WE && I_REG_ADDR == `SPICS_CTRL_ADDR)
      next_ctrl = I_REG_WDATA;
    if (I_REG_WE && I_REG_ADDR == `SPICS_STAT_ADDR)
      next_dbl = I_REG_WDATA[`SPICS_STAT_DBL]; // [RULE7]
    // A full FIFO drops the byte and flags the collision
    if (data_wr && !fifo_in_ready)
      set_wcol = 1'b1;
    case (state)
      S_IDLE:
      begin
        next_tmr = 8'h00;
        next_cnt = 4'h0;
        next_sck_o = ctrl[`SPICS_CTRL_CPOL]; // [RULE4]
        if (ctrl[`SPICS_CTRL_EN] && ctrl[`SPICS_CTRL_MSTR] && fifo_out_valid && !ss_low)
          start = 1'b1; // [RULE3]
        else if (ctrl[`SPICS_CTRL_EN] && !ctrl[`SPICS_CTRL_MSTR] && ss_fall)
          start = 1'b1;
        if (start)
        begin
          pop = fifo_out_valid;
          next_state = S_XFER;
          // Leading-edge sampling needs the first bit out before any edge
          if (!ctrl[`SPICS_CTRL_CPHA])
          begin
            next_sdo = load_sh[7]; // [RULE5]
            next_sh = {load_sh[6:0], 1'b0};
          end
          else
            next_sh = load_sh;
        end
      end
      S_XFER:
      begin
        if (ctrl[`SPICS_CTRL_MSTR])
        begin
          tick = tmr == half - 8'h01; // [RULE6]
          next_tmr = tick ? 8'h00 : tmr + 8'h01;
          edge_ev = tick;
          if (tick)
            next_sck_o = !sck_o; // [RULE3]
        end
        else
          edge_ev = sck_s != sck_prev;
        if (edge_ev)
        begin
          if (cnt[0] == ctrl[`SPICS_CTRL_CPHA])
          begin
            rx_next = {rx_sh[6:0], sdi_s}; // [RULE5]
            next_rx_sh = rx_next;
          end
          else
          begin
            next_sdo = sh[7];
            next_sh = {sh[6:0], 1'b0};
          end
          next_cnt = cnt + 4'h1;
          if (cnt == 4'hF)
          begin
            next_rx_data = ctrl[`SPICS_CTRL_MSBF] ? rx_next : spics_rev(rx_next); // [RULE2]
            set_pend = 1'b1;
            next_state = S_IDLE;
          end
        end
        // Slave frame ends early if select is released
        if (!ctrl[`SPICS_CTRL_MSTR] && !ss_low)
          next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    // Another master pulling select low forces this one back to slave
    if (ctrl[`SPICS_CTRL_EN] && ctrl[`SPICS_CTRL_MSTR] && ss_low)
    begin
      set_modf = 1'b1;
      next_ctrl[`SPICS_CTRL_MSTR] = 1'b0;
      next_state = S_IDLE;
    end
    if (!ctrl[`SPICS_CTRL_EN])
      next_state = S_IDLE; // [RULE1]
    next_sck_oe = ctrl[`SPICS_CTRL_EN] && ctrl[`SPICS_CTRL_MSTR]; // [RULE1] [RULE3]
    next_sdo_oe = ctrl[`SPICS_CTRL_EN] && (ctrl[`SPICS_CTRL_MSTR] || ss_low); // [RULE1]
    // Reading status clears the flags; a same-cycle event still sets
    next_pend = (pend && !stat_rd) || set_pend; // [RULE7]
    next_wcol = (wcol && !stat_rd) || set_wcol; // [RULE7]
    next_modf = (modf && !stat_rd) || set_modf; // [RULE7]
    next_irq = pend && ctrl[`SPICS_CTRL_IE]; // [RULE8] [RULE1]
    next_tx_rdy = fifo_in_ready;
    next_rdata = rdata;
    if (I_REG_RE)
    begin
      case (I_REG_ADDR)
        `SPICS_CTRL_ADDR: next_rdata = ctrl;
        `SPICS_STAT_ADDR: next_rdata = {pend, wcol, modf, 4'h0, dbl}; // [RULE7]
        `SPICS_DATA_ADDR: next_rdata = rx_data;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state <= S_IDLE;
      ctrl <= `SPICS_CTRL_RESET;
      dbl <= 1'(`SPICS_STAT_RESET >> `SPICS_STAT_DBL);
      pend <= 1'b0;
      wcol <= 1'b0;
      modf <= 1'b0;
      tmr <= 8'h00;
      cnt <= 4'h0;
      sh <= 8'h00;
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      irq <= 1'b0;
      rdata <= 8'h00;
      tx_rdy <= 1'b1;
    end
    else
    begin
      state <= next_state;
      ctrl <= next_ctrl;
      dbl <= next_dbl;
      pend <= next_pend;
      wcol <= next_wcol;
      modf <= next_modf;
      tmr <= next_tmr;
      cnt <= next_cnt;
      sh <= next_sh;
      rx_sh <= next_rx_sh;
      rx_data <= next_rx_data;
      sck_o <= next_sck_o;
      sck_oe <= next_sck_oe;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      irq <= next_irq;
      rdata <= next_rdata;
      tx_rdy <= next_tx_rdy;
    end
  end

  assign O_REG_RDATA = rdata;
  assign O_TX_READY = tx_rdy;
  assign O_IRQ = irq;
  assign O_SERIAL_SHIFT_CLOCK_PIN = sck_o;
  assign O_SERIAL_SHIFT_CLOCK_PIN_OE = sck_oe;
  assign O_SDO = sdo;
  assign O_SDO_OE = sdo_oe;

  // Cycles since the last master clock toggle or frame start
  logic [7:0] gap;
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN)
  begin
    if (!I_RSTN)
      gap <= 8'h00;
    else
      gap <= (tick || start) ? 8'h00 : gap + 8'h01;
  end

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RSTN);

  sequence pend_held_s;
    pend && ctrl[`SPICS_CTRL_IE] ##1 pend && ctrl[`SPICS_CTRL_IE];
  endsequence
  sequence fault_s;
    ctrl[`SPICS_CTRL_EN] && ctrl[`SPICS_CTRL_MSTR] && ss_low;
  endsequence
  sequence byte_done_s;
    state == S_XFER && edge_ev && cnt == 4'hF;
  endsequence

  irq_gate_a: assert property (pend_held_s |-> O_IRQ) // [RULE8]
    else $error("irq missing while pending and enabled");
  irq_mask_a: assert property (!ctrl[`SPICS_CTRL_IE] |=> !O_IRQ) // [RULE1]
    else $error("irq raised while disabled");
  port_off_a: assert property (!ctrl[`SPICS_CTRL_EN] |=>
      state == S_IDLE && !O_SDO_OE && !O_SERIAL_SHIFT_CLOCK_PIN_OE) // [RULE1]
    else $error("port active while disabled");
  bit_order_a: assert property (start && ctrl[`SPICS_CTRL_CPHA] |=>
      sh == ($past(ctrl[`SPICS_CTRL_MSBF]) ? $past(load_val) : spics_rev($past(load_val)))) // [RULE2]
    else $error("shift register loaded in wrong order");
  slave_clock_a: assert property (!ctrl[`SPICS_CTRL_MSTR] |=> !O_SERIAL_SHIFT_CLOCK_PIN_OE) // [RULE3]
    else $error("slave drives shift clock");
  idle_level_a: assert property (state == S_IDLE && $past(state) == S_IDLE
      && $stable(ctrl[`SPICS_CTRL_CPOL]) |-> O_SERIAL_SHIFT_CLOCK_PIN == ctrl[`SPICS_CTRL_CPOL]) // [RULE4]
    else $error("shift clock not at idle level");
  sample_edge_a: assert property (state == S_XFER && edge_ev
      && cnt[0] == ctrl[`SPICS_CTRL_CPHA] |=> rx_sh[0] == $past(sdi_s)) // [RULE5]
    else $error("data not sampled on selected edge");
  drive_edge_a: assert property (state == S_XFER && edge_ev
      && cnt[0] != ctrl[`SPICS_CTRL_CPHA] |=> $stable(rx_sh)) // [RULE5]
    else $error("data sampled on driving edge");
  shift_rate_a: assert property (tick |-> gap == half - 8'h01) // [RULE6]
    else $error("shift clock half period wrong");
  status_read_a: assert property (stat_rd |=> O_REG_RDATA[4:1] == 4'h0
      && O_REG_RDATA[7] == $past(pend) && O_REG_RDATA[0] == $past(dbl)) // [RULE7]
    else $error("status readback wrong");
  done_flag_a: assert property (byte_done_s |=> pend && state == S_IDLE) // [RULE7]
    else $error("pending flag not set at byte end");
  mode_fault_a: assert property (fault_s |=> modf && !ctrl[`SPICS_CTRL_MSTR]
      ##1 !O_SERIAL_SHIFT_CLOCK_PIN_OE) // [RULE3]
    else $error("mode fault not handled");

endmodule : spics_top

// ### tb/spics_peer.sv
// Behavioural serial peripheral that answers the port in master role.
// Assumes a clean registered shift clock that rests at its idle level.
`timescale 1ns/1ps

module spics_peer
(
  // Link
  input wire logic i_sck,
  input wire logic i_sck_oe,
  input wire logic i_sdo,
  output logic o_sdi,
  // Frame setup
  input wire logic i_cpol,
  input wire logic i_cpha,
  input wire logic i_msbf,
  input wire logic [7:0] i_reply,
  output logic [7:0] o_rx
);
  int e = 0;
  int idx;
  logic b;
  initial o_rx = 8'h00;
  always @(negedge i_sck_oe) e = 0;
  // An idle-level move at enable has an even count and is skipped
  always @(i_sck)
  begin
    if (i_sck_oe === 1'b1)
    begin
      if (i_sck !== i_cpol)
        e = (e >= 16) ? 1 : e + 1;
      else if (e % 2 == 1)
        e = e + 1;
      if ((e % 2 == 1) ^ i_cpha)
        o_rx[i_msbf ? 7 - (e - 1) / 2 : (e - 1) / 2] = i_sdo;
    end
  end
  always_comb
  begin
    idx = i_cpha ? ((e > 0) ? (e - 1) / 2 : 0) : ((e >= 16) ? 0 : e / 2);
    b = i_reply[i_msbf ? 7 - idx : idx];
    // Released line shows the inverse, never a stale bit
    o_sdi = i_sck_oe ? b : ~b;
  end
endmodule : spics_peer

// ### tb/spi_control_status_tb.sv
// Self-checking bench for the serial port control and status block.
// Assumes spics_peer stands on the link; select is driven by the bench.
`timescale 1ns/1ps
`include "spics_regs.svh"

module spi_control_status_tb;
  logic clk, rstn, we, re, txr, irq, sck_o, sck_oe, sdo, sdo_oe, ss_n, sdi;
  logic cpol, cpha, msbf;
  logic [7:0] addr, wdata, rdata, reply, rx;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int hcnt = 0;
  wire sck_w = sck_oe ? sck_o : 1'b0;

  spics_top u_spics_top (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_REG_ADDR(addr),
    .I_REG_WE(we), .I_REG_RE(re), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
    .O_TX_READY(txr), .O_IRQ(irq), .I_SERIAL_SHIFT_CLOCK_PIN(sck_w),
    .O_SERIAL_SHIFT_CLOCK_PIN(sck_o), .O_SERIAL_SHIFT_CLOCK_PIN_OE(sck_oe),
    .I_SDI(sdi), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_SS_N(ss_n));
  spics_peer u_spics_peer (.i_sck(sck_w), .i_sck_oe(sck_oe), .i_sdo(sdo),
    .o_sdi(sdi), .i_cpol(cpol), .i_cpha(cpha), .i_msbf(msbf),
    .i_reply(reply), .o_rx(rx));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cycles spent away from the idle level, and the hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (sck_oe === 1'b1 && sck_o !== cpol)
      hcnt++;
    if (cyc > 20000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string nm, input int exp, input int got);
    n_checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_n

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    #1;
    d = rdata;
  endtask : rd

  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic t_regs;
    logic [7:0] g;
    rd(`SPICS_CTRL_ADDR, g);
    chk("ctrl reset", 8'h00, g);
    rd(`SPICS_STAT_ADDR, g);
    chk("stat reset", 8'h00, g);
    wr(`SPICS_STAT_ADDR, 8'hFF);
    rd(`SPICS_STAT_ADDR, g);
    chk("stat rw", 8'h01, g);
    wr(`SPICS_CTRL_ADDR, 8'h2F);
    rd(`SPICS_CTRL_ADDR, g);
    chk("ctrl rw", 8'h2F, g);
    wr(8'hE8, 8'hFF);
    rd(8'hE8, g);
    chk("unmapped", 8'h00, g);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_xfer(input int i);
    logic [7:0] g, d;
    int half;
    k_wait(0);
    wr(`SPICS_CTRL_ADDR, 8'h00);
    {msbf, cpha, cpol} = 3'(i);
    d = 8'hA7 + 8'(i);
    reply = ~d;
    half = i[2] ? (4 << (2 * i[1:0])) / 4 : (4 << (2 * i[1:0])) / 2;
    wr(`SPICS_STAT_ADDR, {7'h00, i[2]});
    wr(`SPICS_CTRL_ADDR, {2'b11, msbf, 1'b1, cpol, cpha, 2'(i)});
    settle();
    chk("sck oe", 8'h01, {7'h00, sck_oe});
    chk("sck idle", {7'h00, cpol}, {7'h00, sck_o});
    hcnt = 0;
    wr(`SPICS_DATA_ADDR, d);
    k_wait(1);
    chk("irq", 8'h01, {7'h00, irq});
    chk("sck end", {7'h00, cpol}, {7'h00, sck_o});
    chk_n("active cycles", 8 * half, hcnt);
    chk("peer rx", d, rx);
    rd(`SPICS_DATA_ADDR, g);
    if (i[1:0] != 0)
      chk("rx", reply, g);
    rd(`SPICS_STAT_ADDR, g);
    chk("stat done", {1'b1, 6'h00, i[2]}, g);
    settle();
    chk("irq clear", 8'h00, {7'h00, irq});
    $display("t_xfer %0d done", i);
  endtask : t_xfer

  // Waits a bounded time for the interrupt, or for the peer's last byte
  task automatic k_wait(input int m);
    int k;
    k = 0;
    while (k < 3000 && (m == 1 ? irq !== 1'b1 : m == 2 ? rx !== 8'h0F : 0))
    begin
      @(posedge clk);
      k++;
    end
    settle();
  endtask : k_wait

  task automatic t_fifo;
    logic [7:0] g;
    wr(`SPICS_CTRL_ADDR, 8'h00);
    {msbf, cpha, cpol} = 3'h0;
    wr(`SPICS_STAT_ADDR, 8'h00);
    wr(`SPICS_CTRL_ADDR, 8'h10);
    for (int k = 0; k < 16; k++)
      wr(`SPICS_DATA_ADDR, 8'(k));
    settle();
    chk("tx ready full", 8'h00, {7'h00, txr});
    chk("off oe", 8'h00, {7'h00, sck_oe});
    wr(`SPICS_DATA_ADDR, 8'hEE);
    rd(`SPICS_STAT_ADDR, g);
    chk("stat wcol", 8'h40, g);
    wr(`SPICS_CTRL_ADDR, 8'h50);
    k_wait(2);
    repeat (4) settle();
    chk("tx ready empty", 8'h01, {7'h00, txr});
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(`SPICS_STAT_ADDR, g);
    chk("stat pend", 8'h80, g);
    $display("t_fifo done");
  endtask : t_fifo

  task automatic t_modf;
    logic [7:0] g;
    wr(`SPICS_CTRL_ADDR, 8'h40);
    settle();
    chk("slave oe", 8'h00, {7'h00, sck_oe});
    wr(`SPICS_CTRL_ADDR, 8'h50);
    @(posedge clk);
    ss_n <= 1'b0;
    repeat (6) settle();
    rd(`SPICS_STAT_ADDR, g);
    chk("stat modf", 8'h20, g);
    rd(`SPICS_CTRL_ADDR, g);
    chk("ctrl modf", 8'h40, g);
    chk("modf oe", 8'h00, {7'h00, sck_oe});
    @(posedge clk);
    ss_n <= 1'b1;
    $display("t_modf done");
  endtask : t_modf

  initial
  begin
    rstn = 1'b0;
    {we, re, ss_n} = 3'b001;
    {addr, wdata, reply} = 24'h000000;
    {msbf, cpha, cpol} = 3'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    for (int i = 0; i < 8; i++)
      t_xfer(i);
    t_fifo();
    t_modf();
    report_and_stop();
  end
endmodule : spi_control_status_tb
